// *** common/msdbs_regs.vh ***
// register map, field layout and constants of the stop and brake sequencer
`ifndef MSDBS_REGS_VH
`define MSDBS_REGS_VH
`define MSDBS_A_CTRL      5'h00
`define MSDBS_A_BRAKE     5'h04
`define MSDBS_A_DECEL     5'h08
`define MSDBS_A_MFI       5'h0C
`define MSDBS_A_STAT      5'h10
`define MSDBS_A_LOCK      5'h14
`define MSDBS_A_FMAX      5'h18
`define MSDBS_AW          5
// ctrl fields
`define MSDBS_F_METH      1:0
`define MSDBS_F_UNIT      2
`define MSDBS_F_AI2       7:4
// brake fields
`define MSDBS_F_PCT       6:0
`define MSDBS_F_SBT       25:16
// decel fields
`define MSDBS_F_DEC       15:0
`define MSDBS_F_DSTOP     31:16
// reset values
`define MSDBS_R_METH      2'h0
`define MSDBS_R_UNIT      1'h1
`define MSDBS_R_AI2       4'hF
`define MSDBS_R_PCT       7'h32
`define MSDBS_R_SBT       10'h000
`define MSDBS_R_DEC       16'h0064
`define MSDBS_R_DSTOP     16'h0064
`define MSDBS_R_MFI       32'hFFFFFFFF
// setting limits
`define MSDBS_MAX_PCT     7'h64
`define MSDBS_MAX_SBT     10'h3E8
`define MSDBS_MAX_TIME    16'hEA60
// stop methods
`define MSDBS_M_RAMP      2'h0
`define MSDBS_M_COAST     2'h1
`define MSDBS_M_DCB       2'h2
`define MSDBS_M_TIMER     2'h3
// function codes
`define MSDBS_C_DCB       8'h3C
`define MSDBS_C_XNO       8'h0F
`define MSDBS_C_XNC       8'h11
`define MSDBS_C_AICUR     4'h6
`define MSDBS_C_AIOT      4'h7
// timer tick: 10 ms in ns
`define MSDBS_TICK_NS     10000000
`define MSDBS_CLK_NS      10
`define MSDBS_TENTH       24'h00000A
`endif

// *** logic/msdbs_seq.v ***
// stop method, dc injection brake and external decel stop sequencer
`timescale 1ns/1ns
`default_nettype none
`include "msdbs_regs.vh"
// Function
// - four stop methods: ramp, coast, brake, timer
// - method 3 cuts output at stop
// - method 3 ignores run during lockout
// - start brake time up to 10.00 s
// - zero start time skips start braking
// - brake current percent 0..100, default 50
// - code 60 input brakes while stopped
// - run or jog cancels terminal braking
// - analog 2 code 6 sets brake current
// - analog code 7 brakes only on overtorque
// - code 15/17 input ramps with stop time
// - external stop holds until stopped, released
// - stop time 0.0..6000.0 s, fault ramp
// - unit select 0 gives 0.01 s resolution
module msdbs_seq #(
  parameter NMFI     = 4,
  parameter AIW      = 10,
  parameter FW       = 16,
  parameter FMAX_DEF = 16'h1770,
  parameter TICK_CYC = `MSDBS_TICK_NS / `MSDBS_CLK_NS
) (
  input  wire              clk,
  input  wire              nrst,
  input  wire [4:0]        address,
  input  wire              read,
  input  wire              write,
  input  wire [31:0]       writedata,
  output reg  [31:0]       readdata,
  output wire              waitrequest,
  input  wire              run_cmd,
  input  wire              jog_cmd,
  input  wire [NMFI-1:0]   mfi_pin,
  input  wire [AIW-1:0]    ai2_level,
  input  wire              overtorque1,
  input  wire              fault_stop,
  input  wire [FW-1:0]     out_freq,
  input  wire              motor_stopped,
  output reg               out_enable,
  output reg               ramp_down,
  output reg               ramp_use_stop_time,
  output reg  [15:0]       ramp_time,
  output reg               time_unit_fine,
  output reg               dc_brake_on,
  output reg  [6:0]        brake_current,
  output reg               run_lockout
);
  localparam S_IDLE  = 3'h0;
  localparam S_SBRK  = 3'h1;
  localparam S_RUN   = 3'h2;
  localparam S_DECEL = 3'h3;
  localparam S_XSTOP = 3'h4;
  localparam S_DCSTP = 3'h5;
  localparam S_TBRK  = 3'h6;
  localparam [AIW-1:0] AI_FS = {AIW{1'b1}};

  reg  [1:0]      meth_r;
  reg             unit_r;
  reg  [3:0]      ai2f_r;
  reg  [6:0]      pct_r;
  reg  [9:0]      sbt_r;
  reg  [15:0]     dec_r;
  reg  [15:0]     dstop_r;
  reg  [31:0]     mfi_r;
  reg  [FW-1:0]   fmax_r;
  reg             ack_r;
  reg  [2:0]      st_r;
  reg  [2:0]      st_nxt;
  reg  [19:0]     lock_r;
  reg  [9:0]      sb_cnt_r;
  reg  [31:0]     div_r;
  wire            tick;
  wire            run_req;
  wire            tbrk_in;
  wire            xstop_in;
  wire [19:0]     lock_val;
  wire [6:0]      ai_pct;
  wire            wr_go;
  wire            lock_busy;
  wire [15:0]     pct_cl;
  wire [15:0]     sbt_cl;

  // true when any terminal programmed with code is asserted
  function mfi_hit;
    input [31:0]     codes;
    input [NMFI-1:0] pins;
    input [7:0]      code;
    input            nc;
    integer          i;
    begin
      mfi_hit = 1'b0;
      for (i = 0; i < NMFI; i = i + 1) begin
        if (codes[i*8 +: 8] == code && (pins[i] ^ nc))
          mfi_hit = 1'b1;
      end
    end
  endfunction

  // saturate a write to a limit
  function [15:0] clamp;
    input [15:0] v;
    input [15:0] lim;
    begin
      clamp = (v > lim) ? lim : v;
    end
  endfunction

  // wait one cycle on every access, answer on the second
  assign waitrequest = (read | write) & ~ack_r;
  assign wr_go       = write & ack_r;
  assign pct_cl      = clamp({9'h000, writedata[`MSDBS_F_PCT]},
                             {9'h000, `MSDBS_MAX_PCT});
  assign sbt_cl      = clamp({6'h00, writedata[`MSDBS_F_SBT]},
                             {6'h00, `MSDBS_MAX_SBT});

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_r    <= 1'b0;
      readdata <= 32'h00000000;
    end else begin
      ack_r <= (read | write) & ~ack_r;
      if (read & ~ack_r) begin
        case (address)
          `MSDBS_A_CTRL:  readdata <= {24'h000000, ai2f_r, 1'b0, unit_r,
                                       meth_r};
          `MSDBS_A_BRAKE: readdata <= {6'h00, sbt_r, 9'h000, pct_r};
          `MSDBS_A_DECEL: readdata <= {dstop_r, dec_r};
          `MSDBS_A_MFI:   readdata <= mfi_r;
          `MSDBS_A_STAT:  readdata <= {16'h0000, 1'b0, brake_current,
                                       run_lockout, dc_brake_on,
                                       ramp_down, out_enable, 1'b0, st_r};
          `MSDBS_A_LOCK:  readdata <= {12'h000, lock_r};
          `MSDBS_A_FMAX:  readdata <= {{(32-FW){1'b0}}, fmax_r};
          default:        readdata <= 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meth_r  <= `MSDBS_R_METH;
      unit_r  <= `MSDBS_R_UNIT;
      ai2f_r  <= `MSDBS_R_AI2;
      pct_r   <= `MSDBS_R_PCT;
      sbt_r   <= `MSDBS_R_SBT;
      dec_r   <= `MSDBS_R_DEC;
      dstop_r <= `MSDBS_R_DSTOP;
      mfi_r   <= `MSDBS_R_MFI;
      fmax_r  <= FMAX_DEF;
    end else if (wr_go) begin
      case (address)
        `MSDBS_A_CTRL: begin
          meth_r <= writedata[`MSDBS_F_METH];
          unit_r <= writedata[`MSDBS_F_UNIT];
          ai2f_r <= writedata[`MSDBS_F_AI2];
        end
        `MSDBS_A_BRAKE: begin
          pct_r <= pct_cl[6:0];
          sbt_r <= sbt_cl[9:0];
        end
        `MSDBS_A_DECEL: begin
          // same count limit: 600.00 s fine or 6000.0 s coarse
          dec_r   <= clamp(writedata[`MSDBS_F_DEC], `MSDBS_MAX_TIME);
          dstop_r <= clamp(writedata[`MSDBS_F_DSTOP], `MSDBS_MAX_TIME);
        end
        `MSDBS_A_MFI:  mfi_r <= writedata;
        `MSDBS_A_FMAX: fmax_r <= (writedata[FW-1:0] == {FW{1'b0}}) ?
                                 fmax_r : writedata[FW-1:0];
        default: ;
      endcase
    end
  end

  // 10 ms timer tick
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      div_r <= 32'h00000000;
    else if (div_r >= TICK_CYC - 1)
      div_r <= 32'h00000000;
    else
      div_r <= div_r + 32'h00000001;
  end
  assign tick = (div_r >= TICK_CYC - 1);

  assign run_req  = run_cmd | jog_cmd;
  // gate on the counter itself: the registered flag lags the load by a cycle
  assign lock_busy = (lock_r != 20'h00000);
  assign tbrk_in  = mfi_hit(mfi_r, mfi_pin, `MSDBS_C_DCB, 1'b0);
  assign xstop_in = mfi_hit(mfi_r, mfi_pin, `MSDBS_C_XNO, 1'b0) |
                    mfi_hit(mfi_r, mfi_pin, `MSDBS_C_XNC, 1'b1);

  // lockout in 10 ms ticks; coarse unit counts ten per setting step
  wire [23:0] dec_t  = unit_r ? dec_r * `MSDBS_TENTH
                              : {8'h00, dec_r};
  wire [23+FW:0] prod = dec_t * out_freq;
  wire [23+FW:0] quot = prod / fmax_r;
  assign lock_val = (quot > 20'hFFFFF) ? 20'hFFFFF : quot[19:0];

  // analog full scale maps to 100 percent
  wire [AIW+6:0] ai_mul = ai2_level * `MSDBS_MAX_PCT;
  wire [AIW+6:0] ai_div = ai_mul / AI_FS;
  assign ai_pct = ai_div[6:0];

  always @* begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE: begin
        if (xstop_in | fault_stop)
          st_nxt = S_IDLE;
        else if (run_req & ~lock_busy)
          st_nxt = (sbt_r == 10'h000) ? S_RUN : S_SBRK;
        else if (tbrk_in & ~run_req)
          st_nxt = S_TBRK;
      end
      S_SBRK: begin
        if (~run_req)
          st_nxt = S_IDLE;
        else if (sb_cnt_r == 10'h000)
          st_nxt = S_RUN;
      end
      S_RUN: begin
        if (xstop_in | fault_stop)
          st_nxt = S_XSTOP;
        else if (~run_req) begin
          case (meth_r)
            `MSDBS_M_RAMP:  st_nxt = S_DECEL;
            `MSDBS_M_DCB:   st_nxt = S_DCSTP;
            default:        st_nxt = S_IDLE;
          endcase
        end
      end
      S_DECEL: begin
        if (xstop_in | fault_stop)
          st_nxt = S_XSTOP;
        else if (run_req)
          st_nxt = S_RUN;
        else if (motor_stopped)
          st_nxt = S_IDLE;
      end
      S_XSTOP: begin
        // no restart before standstill and release of both commands
        if (motor_stopped & ~run_req & ~xstop_in & ~fault_stop)
          st_nxt = S_IDLE;
      end
      S_DCSTP: begin
        if (motor_stopped)
          st_nxt = S_IDLE;
      end
      S_TBRK: begin
        if (run_req)
          st_nxt = lock_busy ? S_IDLE : S_RUN;
        else if (~tbrk_in)
          st_nxt = S_IDLE;
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r     <= S_IDLE;
      lock_r   <= 20'h00000;
      sb_cnt_r <= 10'h000;
    end else begin
      st_r <= st_nxt;
      if (st_r == S_RUN && st_nxt == S_IDLE && meth_r == `MSDBS_M_TIMER)
        lock_r <= lock_val;
      else if (tick && lock_r != 20'h00000)
        lock_r <= lock_r - 20'h00001;
      if (st_nxt == S_SBRK && st_r != S_SBRK)
        sb_cnt_r <= sbt_r;
      else if (tick && sb_cnt_r != 10'h000)
        sb_cnt_r <= sb_cnt_r - 10'h001;
    end
  end

  // outputs registered; the state-driven ones from the next state
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_enable         <= 1'b0;
      ramp_down          <= 1'b0;
      ramp_use_stop_time <= 1'b0;
      ramp_time          <= `MSDBS_R_DEC;
      time_unit_fine     <= 1'b0;
      dc_brake_on        <= 1'b0;
      brake_current      <= `MSDBS_R_PCT;
      run_lockout        <= 1'b0;
    end else begin
      out_enable <= (st_nxt == S_RUN) | (st_nxt == S_DECEL) |
                    (st_nxt == S_XSTOP);
      ramp_down  <= (st_nxt == S_DECEL) | (st_nxt == S_XSTOP);
      ramp_use_stop_time <= (st_nxt == S_XSTOP);
      ramp_time  <= (st_nxt == S_XSTOP) ? dstop_r : dec_r;
      time_unit_fine <= ~unit_r;
      // overtorque gating when analog input 2 is given code 7
      dc_brake_on <= ((st_nxt == S_SBRK) | (st_nxt == S_DCSTP) |
                      (st_nxt == S_TBRK)) &
                     ((ai2f_r != `MSDBS_C_AIOT) | overtorque1);
      brake_current <= (ai2f_r == `MSDBS_C_AICUR) ? ai_pct : pct_r;
      run_lockout <= (lock_r != 20'h00000) &
                     ~(tick && lock_r == 20'h00001);
    end
  end
endmodule // msdbs_seq
`default_nettype wire

// *** tb/msdbs_chk.sv ***
// port checker of the stop and brake sequencer
`timescale 1ns/1ns
`default_nettype none
module msdbs_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        read,
  input wire logic        write,
  input wire logic        waitrequest,
  input wire logic        run_cmd,
  input wire logic        jog_cmd,
  input wire logic        fault_stop,
  input wire logic        out_enable,
  input wire logic        ramp_down,
  input wire logic        ramp_use_stop_time,
  input wire logic [15:0] ramp_time,
  input wire logic        dc_brake_on,
  input wire logic [6:0]  brake_current,
  input wire logic        run_lockout
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  AST_WAIT_FIRST: assert property ($rose(read | write) |-> waitrequest ##1
    !waitrequest) else $error("bus answer not in second cycle");
  AST_IDLE_NOWAIT: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest without request");
  AST_PCT_MAX: assert property (brake_current <= 7'h64)
    else $error("brake current above rated");
  AST_TIME_MAX: assert property (ramp_time <= 16'hEA60)
    else $error("ramp time above limit");
  AST_LOCK_OFF: assert property (run_lockout |-> !out_enable)
    else $error("output on during lockout");
  AST_OE_CAUSE: assert property ($rose(out_enable) |-> $past(run_cmd || jog_cmd))
    else $error("output on without run or jog");
  AST_FAULT: assert property (fault_stop && out_enable |=> ramp_down && ramp_use_stop_time)
    else $error("fault did not start stop ramp");
  AST_STOP_RAMP: assert property (ramp_use_stop_time |-> ramp_down)
    else $error("stop time used without ramp");
  COV_LOCK: cover property ($rose(run_lockout));
  COV_BRAKE: cover property ($rose(dc_brake_on));
  COV_XSTOP: cover property ($rose(ramp_use_stop_time));
endmodule // msdbs_chk
bind msdbs_seq msdbs_chk u_chk (.clk(clk), .nrst(nrst), .read(read),
  .write(write), .waitrequest(waitrequest), .run_cmd(run_cmd),
  .jog_cmd(jog_cmd), .fault_stop(fault_stop), .out_enable(out_enable),
  .ramp_down(ramp_down), .ramp_use_stop_time(ramp_use_stop_time),
  .ramp_time(ramp_time), .dc_brake_on(dc_brake_on),
  .brake_current(brake_current), .run_lockout(run_lockout));
`default_nettype wire

// *** tb/msdbs_motor.sv ***
// behavioural motor: spins up on output, coasts, brakes hard
`timescale 1ns/1ns
`default_nettype none
module msdbs_motor (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        out_enable,
  input  wire logic        ramp_down,
  input  wire logic        dc_brake_on,
  output var  logic [15:0] out_freq,
  output wire logic        motor_stopped
);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      out_freq <= 16'h0000;
    else if (dc_brake_on)
      out_freq <= (out_freq > 16'h00C8) ? out_freq - 16'h00C8 : 16'h0000;
    else if (out_enable && !ramp_down)
      out_freq <= (out_freq < 16'h0BB8) ? out_freq + 16'h0064 : 16'h0BB8;
    else
      out_freq <= (out_freq > 16'h0014) ? out_freq - 16'h0014 : 16'h0000;
  end
  // standstill only at true zero, so restart waits the full coast
  assign motor_stopped = (out_freq == 16'h0000);
endmodule // msdbs_motor
`default_nettype wire

// *** tb/test_motor_stop_dc_brake_sequencer.sv ***
// self-checking bench of the stop and brake sequencer
`timescale 1ns/1ns
`default_nettype none
`include "msdbs_regs.vh"
module test_motor_stop_dc_brake_sequencer;
  logic        clk, nrst, read, write, run_cmd, jog_cmd, overtorque1;
  logic        fault_stop, waitrequest, out_enable, ramp_down, motor_stopped;
  logic        ramp_use_stop_time, time_unit_fine, dc_brake_on, run_lockout;
  logic [4:0]  address;
  logic [3:0]  mfi_pin;
  logic [9:0]  ai2_level;
  logic [6:0]  brake_current;
  logic [15:0] out_freq, ramp_time;
  logic [31:0] writedata, readdata, rv;
  int          n_errors, compares, cyc, n;
  msdbs_seq #(.TICK_CYC(10)) dut (.clk(clk), .nrst(nrst), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .run_cmd(run_cmd), .jog_cmd(jog_cmd),
    .mfi_pin(mfi_pin), .ai2_level(ai2_level), .overtorque1(overtorque1),
    .fault_stop(fault_stop), .out_freq(out_freq),
    .motor_stopped(motor_stopped), .out_enable(out_enable),
    .ramp_down(ramp_down), .ramp_use_stop_time(ramp_use_stop_time),
    .ramp_time(ramp_time), .time_unit_fine(time_unit_fine),
    .dc_brake_on(dc_brake_on), .brake_current(brake_current),
    .run_lockout(run_lockout));
  msdbs_motor motor (.clk(clk), .nrst(nrst), .out_enable(out_enable),
    .ramp_down(ramp_down), .dc_brake_on(dc_brake_on), .out_freq(out_freq),
    .motor_stopped(motor_stopped));
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmpb(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask
  task automatic ticks(input int k);
    repeat (k) @(posedge clk);
  endtask
  // one request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    rv = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp(rv, e);
  endtask
  function automatic logic pick(input int s);
    return s == 0 ? out_enable : (s == 1 ? run_lockout : motor_stopped);
  endfunction
  task automatic wait_on(input int s, input logic lvl);
    n = 0;
    @(posedge clk);
    while (pick(s) !== lvl && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      n_errors++;
      $display("MISMATCH t=%0t wait limit reached", $time);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    {nrst, read, write, run_cmd, jog_cmd, overtorque1, fault_stop} <= 7'h00;
    address <= 5'h00;
    writedata <= 32'h0;
    mfi_pin <= 4'h0;
    ai2_level <= 10'h3FF;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rdc(`MSDBS_A_CTRL, 32'h000000F4);
    rdc(`MSDBS_A_BRAKE, 32'h00000032);
    rdc(`MSDBS_A_DECEL, 32'h00640064);
    rdc(`MSDBS_A_MFI, 32'hFFFFFFFF);
    rdc(`MSDBS_A_STAT, 32'h00003200);
    rdc(`MSDBS_A_LOCK, 32'h00000000);
    bus(1'b1, 5'h1C, 32'hFFFFFFFF);
    rdc(5'h1C, 32'h0);
    bus(1'b1, `MSDBS_A_BRAKE, 32'h03FF007F);
    rdc(`MSDBS_A_BRAKE, 32'h03E80064);
    bus(1'b1, `MSDBS_A_DECEL, 32'hFFFFFFFF);
    rdc(`MSDBS_A_DECEL, 32'hEA60EA60);
    bus(1'b1, `MSDBS_A_DECEL, 32'h00C80064);
    bus(1'b1, `MSDBS_A_BRAKE, 32'h00000032);
    bus(1'b1, `MSDBS_A_CTRL, 32'h000000F3);
    ticks(2);
    cmpb(time_unit_fine, 1'b1);
    $display("test settings done");
    run_cmd <= 1'b1;
    ticks(2);
    cmpb(out_enable & !dc_brake_on, 1'b1);
    ticks(50);
    run_cmd <= 1'b0;
    ticks(1);
    run_cmd <= 1'b1;
    ticks(1);
    cmpb(out_enable, 1'b0);
    ticks(3);
    cmpb(run_lockout & !out_enable, 1'b1);
    run_cmd <= 1'b0;
    // half of full frequency times 100 counts: 50 ticks of 10 cycles
    wait_on(1, 1'b0);
    cmpb(n >= 470 && n <= 510, 1'b1);
    wait_on(2, 1'b1);
    $display("test coast timer done");
    bus(1'b1, `MSDBS_A_BRAKE, 32'h00030028);
    run_cmd <= 1'b1;
    ticks(2);
    cmpb(dc_brake_on, 1'b1);
    cmp({25'h0, brake_current}, 32'h28);
    wait_on(0, 1'b1);
    cmpb(n >= 18 && n <= 31, 1'b1);
    bus(1'b1, `MSDBS_A_CTRL, 32'h00000071);
    run_cmd <= 1'b0;
    wait_on(2, 1'b1);
    $display("test start brake done");
    bus(1'b1, `MSDBS_A_BRAKE, 32'h00000028);
    bus(1'b1, `MSDBS_A_MFI, 32'hFFFF0F3C);
    mfi_pin <= 4'h1;
    ticks(3);
    cmpb(dc_brake_on, 1'b0);
    overtorque1 <= 1'b1;
    ticks(3);
    cmpb(dc_brake_on, 1'b1);
    bus(1'b1, `MSDBS_A_CTRL, 32'h00000061);
    ticks(3);
    cmpb(dc_brake_on, 1'b1);
    cmp({25'h0, brake_current}, 32'h64);
    jog_cmd <= 1'b1;
    ticks(4);
    cmpb(out_enable & !dc_brake_on, 1'b1);
    $display("test terminal brake done");
    ticks(40);
    mfi_pin <= 4'h2;
    ticks(2);
    cmpb(ramp_down & ramp_use_stop_time, 1'b1);
    cmp({16'h0, ramp_time}, 32'h00C8);
    mfi_pin <= 4'h0;
    wait_on(2, 1'b1);
    ticks(2);
    cmpb(ramp_down, 1'b1);
    jog_cmd <= 1'b0;
    ticks(3);
    cmpb(ramp_down, 1'b0);
    run_cmd <= 1'b1;
    wait_on(0, 1'b1);
    fault_stop <= 1'b1;
    ticks(2);
    cmpb(ramp_use_stop_time, 1'b1);
    fault_stop <= 1'b0;
    run_cmd <= 1'b0;
    wait_on(2, 1'b1);
    mfi_pin <= 4'h4;
    bus(1'b1, `MSDBS_A_MFI, 32'hFF110F3C);
    run_cmd <= 1'b1;
    wait_on(0, 1'b1);
    mfi_pin <= 4'h0;
    ticks(2);
    cmpb(ramp_use_stop_time & ramp_down, 1'b1);
    mfi_pin <= 4'h4;
    run_cmd <= 1'b0;
    wait_on(2, 1'b1);
    ticks(2);
    cmpb(ramp_down, 1'b0);
    $display("test external stop done");
    bus(1'b1, `MSDBS_A_CTRL, 32'h000000F0);
    run_cmd <= 1'b1;
    wait_on(0, 1'b1);
    ticks(20);
    run_cmd <= 1'b0;
    ticks(2);
    cmpb(ramp_down & out_enable & !ramp_use_stop_time, 1'b1);
    cmp({16'h0, ramp_time}, 32'h0064);
    wait_on(0, 1'b0);
    cmpb(motor_stopped, 1'b1);
    bus(1'b1, `MSDBS_A_CTRL, 32'h000000F2);
    run_cmd <= 1'b1;
    wait_on(0, 1'b1);
    ticks(20);
    run_cmd <= 1'b0;
    ticks(2);
    cmpb(dc_brake_on & !out_enable, 1'b1);
    cmp({25'h0, brake_current}, 32'h28);
    wait_on(2, 1'b1);
    ticks(2);
    cmpb(dc_brake_on, 1'b0);
    $display("test stop methods done");
    report_and_stop();
  end
endmodule // test_motor_stop_dc_brake_sequencer
`default_nettype wire
